/* File: verilog/usi_flags_defs.vh */
`ifndef USI_FLAGS_DEFS_VH
`define USI_FLAGS_DEFS_VH
// register byte addresses
`define ADDR_STATUS    12'h000
`define ADDR_CONTROL   12'h004
`define ADDR_DATA      12'h008
`define ADDR_PORT      12'h00c
// status fields
`define ST_START       7
`define ST_OVF         6
`define ST_STOP        5
`define ST_COLL        4
// control fields
`define CT_START_IE    7
`define CT_OVF_IE      6
`define CT_WM_HI       5
`define CT_WM_LO       4
`define CT_CS_HI       3
`define CT_CS_LO       2
`define CT_CLK         1
`define CT_TOGGLE      0
// port/direction register fields
`define PT_DATA_OUT    0
`define PT_CLK_OUT     1
`define PT_DATA_DIR    2
`define PT_CLK_DIR     3
`define PT_GIE         4
// wire modes
`define WM_OFF         2'h0
`define WM_THREE       2'h1
`define WM_TWO         2'h2
`define WM_TWO_HOLD    2'h3
// reset values
`define CONTROL_RST    8'h00
`define PORT_RST       8'h03
`endif

/* File: verilog/usi_flags.v */
// What this block does
// - overflow flag sets on counter wrap 15 to 0
// - overflow irq when flag, enable, global enable
// - write one clears overflow, releases hold
// - pending overflow irq wakes from idle
// - stop flag set on stop, no irq
// - collision is msb differing from data pin
// - counter readable and writable in status
// - counter counts external, timer or software clock
// - external source plus strobe bit: toggle clocks counter
// - external clock counts with no wire mode
// - start irq when flag, enable, global enable
// - overflow irq taken once enables are set
// - wire mode affects outputs, hold and detector only
// - mode 00 disables outputs, hold, detector
// - three-wire: shift msb replaces port data
// - three-wire clock from port toggle
// - two-wire pins open-collector, gated by direction
// - data pulled low if msb or port zero
// - clock pulled low if port zero or hold
// - start condition holds clock until flag cleared
// - two-wire disables pull-ups
// - mode 11 also holds clock on overflow
// - start flag set by detector, cleared by one
// - output latch: msb changes while clock low for external sources, passes through for internal ones; opposite the sampling edge only for rising-edge source 10
// - software strobe shifts and counts once
`include "usi_flags_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module usi_flags (
  // clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // timer compare match, same clock domain
  input  wire        timerMatch,
  // serial data pin
  input  wire        dataPinIn,
  output reg         dataPinOut,
  output reg         dataPinOe,
  output reg         dataPullup,
  // serial clock pin
  input  wire        clockPinIn,
  output reg         clockPinOut,
  output reg         clockPinOe,
  output reg         clockPullup,
  // cpu side
  output wire        overflowIrq,
  output wire        startIrq,
  output wire        idleWake
);

  reg  [7:0] control;
  reg  [7:0] shiftData;
  reg  [7:0] portReg;
  reg  [3:0] counterValue;
  reg        overflowFlag;
  reg        startFlag;
  reg        stopFlag;
  reg        outLatch;
  reg        startHold;
  reg  [2:0] dataSync;
  reg  [2:0] clockSync;
  reg        dataLevel;
  reg        clockLevel;

  wire [1:0] wireMode  = control[`CT_WM_HI:`CT_WM_LO];
  wire [1:0] clkSource = control[`CT_CS_HI:`CT_CS_LO];
  wire       twoWire   = wireMode[1];
  wire       gie       = portReg[`PT_GIE];

  function isReg;
    input [11:0] a;
    input [11:0] target;
    begin
      isReg = (a == target);
    end
  endfunction

  wire access  = psel & penable;
  wire wrEn    = access & pwrite;
  wire wrStat  = wrEn & isReg(paddr, `ADDR_STATUS);
  wire wrCtrl  = wrEn & isReg(paddr, `ADDR_CONTROL);
  wire wrData  = wrEn & isReg(paddr, `ADDR_DATA);
  wire wrPort  = wrEn & isReg(paddr, `ADDR_PORT);
  wire mapped  = isReg(paddr, `ADDR_STATUS) | isReg(paddr, `ADDR_CONTROL) |
                 isReg(paddr, `ADDR_DATA) | isReg(paddr, `ADDR_PORT);
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // pins come from outside: three stages, accept change when 2nd and 3rd agree
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataSync   <= 3'h7;
      clockSync  <= 3'h7;
      dataLevel  <= 1'b1;
      clockLevel <= 1'b1;
    end else begin
      dataSync  <= {dataSync[1:0], dataPinIn};
      clockSync <= {clockSync[1:0], clockPinIn};
      if (dataSync[1] == dataSync[2])
        dataLevel <= dataSync[2];
      if (clockSync[1] == clockSync[2])
        clockLevel <= clockSync[2];
    end
  end

  reg dataPrev;
  reg clockPrev;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataPrev  <= 1'b1;
      clockPrev <= 1'b1;
    end else begin
      dataPrev  <= dataLevel;
      clockPrev <= clockLevel;
    end
  end

  wire clockRise = clockLevel & ~clockPrev;
  wire clockFall = ~clockLevel & clockPrev;
  wire clockEdge = clockRise | clockFall;
  wire dataFall  = ~dataLevel & dataPrev;
  wire dataRise  = dataLevel & ~dataPrev;

  // software strobes are one-shot writes; toggle reads back as zero, clock bit reads back set when written with an external source
  wire strobeClk    = wrCtrl & pwdata[`CT_CLK];
  wire strobeToggle = wrCtrl & pwdata[`CT_TOGGLE];

  // shift and count sources, external clock usable in any wire mode
  reg shiftTick;
  reg countTick;
  always @* begin
    shiftTick = 1'b0;
    countTick = 1'b0;
    case (clkSource)
      2'h0: begin
        shiftTick = strobeClk;
        countTick = strobeClk;
      end
      2'h1: begin
        shiftTick = timerMatch;
        countTick = timerMatch;
      end
      default: begin
        shiftTick = clkSource[0] ? clockFall : clockRise;
        countTick = control[`CT_CLK] ? strobeToggle : clockEdge;
      end
    endcase
  end

  wire [4:0] countSum = {1'b0, counterValue} + 5'h01;
  wire       wrapEvent = countTick & countSum[4];

  // start and stop conditions seen only in two-wire modes
  // detector off outside two-wire
  wire startCond = twoWire & dataFall & clockLevel;
  wire stopCond  = twoWire & dataRise & clockLevel;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      control      <= `CONTROL_RST;
      portReg      <= `PORT_RST;
      shiftData    <= 8'h00;
      counterValue <= 4'h0;
      overflowFlag <= 1'b0;
      startFlag    <= 1'b0;
      stopFlag     <= 1'b0;
      startHold    <= 1'b0;
    end else begin
      if (wrCtrl)
        control <= {pwdata[7:2], pwdata[`CT_CLK] & pwdata[`CT_CS_HI], 1'b0};
      if (wrPort)
        portReg <= {3'h0, pwdata[4:0]};
      // toggle strobe flips clock port bit
      else if (strobeToggle)
        portReg[`PT_CLK_OUT] <= ~portReg[`PT_CLK_OUT];
      // cpu write wins over a shift in the same cycle
      if (wrData)
        shiftData <= pwdata[7:0];
      else if (shiftTick)
        shiftData <= {shiftData[6:0], dataLevel};
      if (wrStat)
        counterValue <= pwdata[3:0];
      else if (countTick)
        counterValue <= countSum[3:0];
      if (wrapEvent)
        overflowFlag <= 1'b1;
      else if (wrStat & pwdata[`ST_OVF])
        overflowFlag <= 1'b0;
      if (startCond)
        startFlag <= 1'b1;
      else if (wrStat & pwdata[`ST_START])
        startFlag <= 1'b0;
      if (stopCond)
        stopFlag <= 1'b1;
      else if (wrStat & pwdata[`ST_STOP])
        stopFlag <= 1'b0;
      // hold armed by start, engaged at next clock fall
      if (!twoWire || !startFlag)
        startHold <= 1'b0;
      else if (clockFall && portReg[`PT_CLK_DIR])
        startHold <= 1'b1;
    end
  end

  // latch transparent for internal clocks, else open while clock low
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      outLatch <= 1'b0;
    else if (!clkSource[1] || !clockLevel)
      outLatch <= wrData ? pwdata[7] : shiftData[7];
  end

  // overflow hold only in mode 11
  wire ovfHold  = (wireMode == `WM_TWO_HOLD) & overflowFlag;
  wire clkLow   = ~portReg[`PT_CLK_OUT] | startHold | ovfHold;
  wire dataLow  = ~outLatch | ~portReg[`PT_DATA_OUT];

  // pin drivers, registered; enable low means driving
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataPinOut  <= 1'b1;
      dataPinOe   <= 1'b1;
      dataPullup  <= 1'b0;
      clockPinOut <= 1'b1;
      clockPinOe  <= 1'b1;
      clockPullup <= 1'b0;
    end else begin
      case (wireMode)
        `WM_THREE: begin
          dataPinOut  <= outLatch;
          dataPinOe   <= ~portReg[`PT_DATA_DIR];
          dataPullup  <= ~portReg[`PT_DATA_DIR] & portReg[`PT_DATA_OUT];
          clockPinOut <= portReg[`PT_CLK_OUT];
          clockPinOe  <= ~portReg[`PT_CLK_DIR];
          clockPullup <= ~portReg[`PT_CLK_DIR] & portReg[`PT_CLK_OUT];
        end
        `WM_TWO, `WM_TWO_HOLD: begin
          dataPinOut  <= 1'b0;
          dataPinOe   <= ~(portReg[`PT_DATA_DIR] & dataLow);
          clockPinOut <= 1'b0;
          clockPinOe  <= ~(portReg[`PT_CLK_DIR] & clkLow);
          dataPullup  <= 1'b0;
          clockPullup <= 1'b0;
        end
        default: begin
          dataPinOut  <= portReg[`PT_DATA_OUT];
          dataPinOe   <= ~portReg[`PT_DATA_DIR];
          dataPullup  <= ~portReg[`PT_DATA_DIR] & portReg[`PT_DATA_OUT];
          clockPinOut <= portReg[`PT_CLK_OUT];
          clockPinOe  <= ~portReg[`PT_CLK_DIR];
          clockPullup <= ~portReg[`PT_CLK_DIR] & portReg[`PT_CLK_OUT];
        end
      endcase
    end
  end

  wire collision = shiftData[7] ^ dataLevel;

  assign overflowIrq = overflowFlag & control[`CT_OVF_IE] & gie;
  assign startIrq    = startFlag & control[`CT_START_IE] & gie;
  // wake from idle on pending overflow
  assign idleWake    = overflowFlag & control[`CT_OVF_IE];

  always @* begin
    prdata = 32'h00000000;
    if (psel & ~pwrite) begin
      case (paddr)
        `ADDR_STATUS:  prdata = {24'h000000, startFlag, overflowFlag, stopFlag, collision, counterValue};
        `ADDR_CONTROL: prdata = {24'h000000, control};
        `ADDR_DATA:    prdata = {24'h000000, shiftData};
        `ADDR_PORT:    prdata = {24'h000000, portReg};
        default:       prdata = 32'h00000000;
      endcase
    end
  end

endmodule // usi_flags
`default_nettype wire

/* File: dv/usi_flags_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usi_flags_defs.vh"
module usi_flags_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // pins and requests
  input wire logic        dataPinOut,
  input wire logic        clockPinOut,
  input wire logic        dataPullup,
  input wire logic        clockPullup,
  input wire logic        overflowIrq,
  input wire logic        idleWake
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  wire       acc = psel && penable;
  wire       rdA = acc && !pwrite;
  wire       wrS = acc && pwrite && paddr == `ADDR_STATUS;
  wire       wrC = acc && pwrite && paddr == `ADDR_CONTROL;
  wire       wrP = acc && pwrite && paddr == `ADDR_PORT;
  wire [7:0] wb  = pwdata[7:0];
  logic      two;
  // mode shadow; pins lag it by one cycle, hence the past term below
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      two <= 1'b0;
    else if (wrC)
      two <= pwdata[5];
  end
  property p_unmap;
    acc && paddr > `ADDR_PORT |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_mapped;
    acc && paddr[1:0] == 2'h0 && paddr <= `ADDR_PORT |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_wake;
    overflowIrq |-> idleWake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on overflow");
  property p_pull;
    two && $past(two) |-> !dataPullup && !clockPullup;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on in two-wire");
  property p_odrain;
    two && $past(two) |-> !dataPinOut && !clockPinOut;
  endproperty
  a_odrain: assert property (p_odrain) else $error("line driven high");
  property p_ctrl;
    $past(wrC, 3) && rdA && paddr == `ADDR_CONTROL |-> (prdata[7:0] & 8'hfd) == ($past(wb, 3) & 8'hfc);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_port;
    $past(wrP, 3) && rdA && paddr == `ADDR_PORT |-> prdata[7:0] == $past(wb, 3);
  endproperty
  a_port: assert property (p_port) else $error("port readback wrong");
  property p_cnt;
    $past(wrS, 3) && rdA && paddr == `ADDR_STATUS |-> ((prdata[7:0] ^ $past(wb, 3)) & 8'h0f) == 8'h00;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter load lost");
endmodule // usi_flags_props
bind usi_flags usi_flags_props usi_flags_props_i (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .dataPinOut, .clockPinOut, .dataPullup, .clockPullup, .overflowIrq, .idleWake);
`default_nettype wire

/* File: dv/serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // device drivers
  input  wire logic dataPinOut,
  input  wire logic dataPinOe,
  input  wire logic clockPinOut,
  input  wire logic clockPinOe,
  // resolved lines
  output wire logic dataPinIn,
  output wire logic clockPinIn
);
  logic sdaLow = 1'b0;
  logic sclLow = 1'b0;
  assign dataPinIn  = !(sdaLow || (!dataPinOe && !dataPinOut));
  assign clockPinIn = !(sclLow || (!clockPinOe && !clockPinOut));
  // half a 125 ns link period per change; clock idles between frames
  task automatic sda(input logic v);
    #62.5 sdaLow = !v;
  endtask
  task automatic scl(input logic v);
    #62.5 sclLow = !v;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      scl(1'b0);
      scl(1'b1);
    end
  endtask
endmodule // serial_peer
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usi_flags_defs.vh"
module testbench;
  logic        ref_clk, nrst, psel, penable, pwrite, timerMatch, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, dataPinIn, dataPinOut, dataPinOe, dataPullup;
  logic        clockPinIn, clockPinOut, clockPinOe, clockPullup, overflowIrq, startIrq, idleWake;
  int          mismatches, cmp_count;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  usi_flags usi_flags_i (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timerMatch, .dataPinIn, .dataPinOut, .dataPinOe, .dataPullup, .clockPinIn, .clockPinOut,
    .clockPinOe, .clockPullup, .overflowIrq, .startIrq, .idleWake);
  serial_peer serial_peer_i (.dataPinOut, .dataPinOe, .clockPinOut, .clockPinOe, .dataPinIn, .clockPinIn);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), {24'h0, e}, rdv);
  endtask
  // lets slow pin synchronisers settle
  task automatic wt;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic t_regs;
    rd(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_PORT, 8'h03);
    xfer(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wr(`ADDR_CONTROL, 8'h07);
    rd(`ADDR_CONTROL, 8'h04);
    rd(`ADDR_PORT, 8'h01);
    wr(`ADDR_PORT, 8'h03);
    rd(`ADDR_PORT, 8'h03);
  endtask
  task automatic t_soft;
    // strobe source must already be selected when the strobe is written
    wr(`ADDR_CONTROL, 8'h40);
    wr(`ADDR_DATA, 8'hff);
    wr(`ADDR_STATUS, 8'h0e);
    rd(`ADDR_STATUS, 8'h0e);
    wr(`ADDR_CONTROL, 8'h42);
    wr(`ADDR_CONTROL, 8'h42);
    rd(`ADDR_STATUS, 8'h40);
    chk("irq masked", 32'h0, {31'h0, overflowIrq});
    wr(`ADDR_PORT, 8'h13);
    @(posedge ref_clk);
    chk("irq", 32'h3, {30'h0, overflowIrq, idleWake});
    wr(`ADDR_STATUS, 8'h00);
    rd(`ADDR_STATUS, 8'h40);
    wr(`ADDR_STATUS, 8'h40);
    rd(`ADDR_STATUS, 8'h00);
    wr(`ADDR_CONTROL, 8'h04);
    timerMatch <= 1'b1;
    @(posedge ref_clk);
    timerMatch <= 1'b0;
    rd(`ADDR_STATUS, 8'h01);
  endtask
  task automatic t_ext;
    wr(`ADDR_CONTROL, 8'h08);
    serial_peer_i.pulses(2);
    wt;
    rd(`ADDR_STATUS, 8'h05);
    wr(`ADDR_CONTROL, 8'h0a);
    wr(`ADDR_CONTROL, 8'h0b);
    rd(`ADDR_STATUS, 8'h06);
    rd(`ADDR_PORT, 8'h11);
  endtask
  task automatic t_two;
    wr(`ADDR_PORT, 8'h1f);
    wr(`ADDR_CONTROL, 8'hb0);
    wt;
    chk("pins", 32'h3, {28'h0, dataPullup, clockPullup, dataPinOe, clockPinOe});
    serial_peer_i.sda(1'b0);
    wt;
    rd(`ADDR_STATUS, 8'h96);
    chk("start irq", 32'h1, {31'h0, startIrq});
    serial_peer_i.scl(1'b0);
    serial_peer_i.scl(1'b1);
    wt;
    chk("start hold", 32'h0, {31'h0, clockPinOe});
    wr(`ADDR_STATUS, 8'h86);
    wt;
    chk("start free", 32'h1, {31'h0, clockPinOe});
    serial_peer_i.sda(1'b1);
    wt;
    rd(`ADDR_STATUS, 8'h26);
    wr(`ADDR_STATUS, 8'h2f);
    wr(`ADDR_CONTROL, 8'hb2);
    wt;
    chk("ovf hold", 32'h0, {31'h0, clockPinOe});
    wr(`ADDR_STATUS, 8'h40);
    wt;
    chk("ovf free", 32'h1, {31'h0, clockPinOe});
  endtask
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // the whole run needs a few microseconds
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timerMatch = 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs;
    t_soft;
    t_ext;
    t_two;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
